/* design/mog_pkg.sv */
// Constants and types for the message object configuration and gateway logic
// Overview of operation
// RULE1 - Remote watch on transmit object copies identifier and length of matching remote frames
// RULE2 - Remote watch setting ignored entirely on receive objects
// RULE3 - Node select clear means node A, set means node B
// RULE4 - Long id select clear uses 11-bit identifier, set uses 29-bit identifier
// RULE5 - Receive object: request sends remote frame; matching data frame payload is stored
// RULE6 - Transmit object: request sends data frame; matching remote sets pending and request
// RULE7 - Length code field holds byte count; hardware may overwrite it in watch/gateway
// RULE8 - Software length code above eight is used as eight, stored value kept
// RULE9 - Received length code above eight stores eight bytes, reads original code
// RULE10 - Receive node pointer picks one of eight interrupt nodes on receive event
// RULE11 - Transmit node pointer picks one of eight interrupt nodes on transmit event
// RULE12 - Reserved configuration bits read zero; software writes zeros
// RULE13 - Gateway frame send set raises destination send request after gateway data
// RULE14 - Gateway frame send is evaluated only for transfers caused by received data
// RULE15 - Remote on gateway transmit object: forward bit picks own or pointed request
// RULE16 - Forward bit evaluated only after remote frame, transmit object, gateway modes
// RULE17 - Software keeps forward bit clear for FIFO members, pointer at source object
// RULE18 - Normal gateway with identifier copy copies identifier to transmitting object
// RULE19 - Normal gateway with length copy copies length code on data frame transfer
// RULE20 - Width, node and direction changes take effect only when object valid is set
// RULE21 - Mode field selects standard, FIFO base, FIFO slave, normal or shared gateway
// RULE22 - Five-bit depth code gives power-of-two FIFO stages up to 32, else invalid
package mog_pkg;
   localparam int NUM_OBJ  = 32;
   localparam int PTR_W    = 5;
   localparam int ID_W     = 29;
   // Register selectors on the host port
   localparam logic [1:0] SEL_CFG  = 2'h0;
   localparam logic [1:0] SEL_FGCR = 2'h1;
   localparam logic [1:0] SEL_CTRL = 2'h2;
   // Object configuration field positions
   localparam int CFG_WATCH = 0;
   localparam int CFG_NODE  = 1;
   localparam int CFG_LONG  = 2;
   localparam int CFG_DIR   = 3;
   localparam int CFG_DLC_L = 4;
   localparam int CFG_RXP_L = 16;
   localparam int CFG_TXP_L = 20;
   localparam logic [31:0] CFG_RW_MASK = 32'h0077_00FF;
   // FIFO/gateway control field positions
   localparam int FG_SEND   = 8;
   localparam int FG_FWD    = 9;
   localparam int FG_IDC    = 10;
   localparam int FG_LENGTH_CODE_COPY   = 11;
   localparam int FG_PTR_L  = 16;
   localparam int FG_MODE_L = 24;
   localparam logic [31:0] FG_RW_MASK  = 32'h071F_6F1F;
   localparam logic [31:0] FG_RESET    = 32'h0000_0000;
   localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
   localparam logic [3:0]  DLC_MAX     = 4'h8;
   // Control element write codes
   localparam logic [1:0] EL_RESET = 2'h1;
   localparam logic [1:0] EL_SET   = 2'h2;
   typedef enum logic [2:0]
   {
      MODE_STD     = 3'h0,
      MODE_FIFO_B  = 3'h2,
      MODE_FIFO_S  = 3'h3,
      MODE_GW_NORM = 3'h4,
      MODE_GW_SHR  = 3'h5
   } mog_mode_type;
endpackage : mog_pkg

/* design/mog_depth_decode.sv */
// Decoder from FIFO depth code to stage count
`timescale 1ns/1ps
`default_nettype none
module mog_depth_decode
(
   input  wire logic [4:0] depth_code,
   output logic      [5:0] stages,
   output logic            code_ok
);
   // Only codes of the form 0..01..1 are legal
   always_comb
   begin
      code_ok = 1'b1;
      stages  = 6'h00;
      case (depth_code)
         5'h00:   stages = 6'h01;
         5'h01:   stages = 6'h02;
         5'h03:   stages = 6'h04;
         5'h07:   stages = 6'h08;
         5'h0F:   stages = 6'h10;
         5'h1F:   stages = 6'h20;
         default: code_ok = 1'b0; // [RULE22]
      endcase
   end
endmodule : mog_depth_decode
`default_nettype wire

/* design/mog_gateway_cfg.sv */
// Message object configuration store with remote watch and gateway actions
`timescale 1ns/1ps
`default_nettype none
module mog_gateway_cfg
#(
   parameter int NUM_OBJ = mog_pkg::NUM_OBJ
)
(
   input  wire logic                      clk,
   input  wire logic                      rstn,
   // Host port
   input  wire logic                      host_wr,
   input  wire logic                      host_rd,
   input  wire logic [1:0]                host_sel,
   input  wire logic [4:0]                host_obj,
   input  wire logic [31:0]               host_wdata,
   output logic      [31:0]               host_rdata,
   // Frame event from the node controllers
   input  wire logic                      ev_valid,
   input  wire logic                      ev_node,
   input  wire logic [4:0]                ev_obj,
   input  wire logic                      ev_remote,
   input  wire logic                      ev_is_rx,
   input  wire logic [28:0]               ev_id,
   input  wire logic [3:0]                ev_dlc,
   // Transmit launch for a selected object
   input  wire logic [4:0]                tx_obj,
   output logic                           tx_remote,
   output logic                           tx_node,
   output logic                           tx_long_id,
   output logic      [28:0]               tx_id,
   output logic      [3:0]                tx_bytes,
   // Status out
   output logic                           store_payload,
   output logic      [3:0]                store_bytes,
   output logic      [4:0]                store_obj,
   output logic      [NUM_OBJ-1:0]        send_request,
   output logic      [NUM_OBJ-1:0]        remote_pending,
   output logic      [7:0]                irq_node_pulse,
   output logic      [5:0]                fifo_stages,
   output logic                           fifo_code_bad
);
   if (NUM_OBJ != 32)
   begin : g_num_obj_check
      $error("NUM_OBJ must be 32 to match the 5-bit object pointer");
   end

   logic [31:0] cfg_mem [NUM_OBJ];
   logic [31:0] fg_mem  [NUM_OBJ];
   logic [28:0] id_mem  [NUM_OBJ];
   // Active copies of width, node, direction and pointer
   logic [2:0]  act_mem [NUM_OBJ];
   logic [4:0]  aptr_mem [NUM_OBJ];
   logic [NUM_OBJ-1:0] valid_reg;
   logic [NUM_OBJ-1:0] rx_irq_en_reg;
   logic [NUM_OBJ-1:0] tx_irq_en_reg;
   logic [NUM_OBJ-1:0] req_reg;
   logic [NUM_OBJ-1:0] rpnd_reg;
   logic [31:0] rdata_reg;
   logic        tx_remote_reg;
   logic        tx_node_reg;
   logic        tx_long_reg;
   logic [28:0] tx_id_reg;
   logic [3:0]  tx_bytes_reg;
   logic        store_reg;
   logic [3:0]  store_bytes_reg;
   logic [4:0]  store_obj_reg;
   logic [7:0]  irq_reg;
   logic [5:0]  stages_reg;
   logic        bad_reg;

   function automatic logic [3:0] clip_dlc(input logic [3:0] d);
      clip_dlc = (d > mog_pkg::DLC_MAX) ? mog_pkg::DLC_MAX : d;
   endfunction : clip_dlc

   function automatic logic [2:0] mode_of(input logic [31:0] fg);
      mode_of = fg[mog_pkg::FG_MODE_L +: 3];
   endfunction : mode_of

   // Event decode for the object that the frame hit
   wire [31:0] ev_cfg      = cfg_mem[ev_obj];
   wire [31:0] ev_fg       = fg_mem[ev_obj];
   wire [2:0]  ev_act      = act_mem[ev_obj];
   wire        ev_dir_tx   = ev_act[2];
   wire        ev_ok       = ev_valid && valid_reg[ev_obj] && (ev_act[0] == ev_node);
   wire [2:0]  ev_mode     = mode_of(ev_fg); // [RULE21]
   wire        ev_gw       = (ev_mode == mog_pkg::MODE_GW_NORM) || (ev_mode == mog_pkg::MODE_GW_SHR);
   wire        ev_gw_norm  = (ev_mode == mog_pkg::MODE_GW_NORM);
   wire [4:0]  ev_ptr      = aptr_mem[ev_obj];
   wire        rx_remote   = ev_ok && ev_is_rx && ev_remote;
   wire        rx_data     = ev_ok && ev_is_rx && !ev_remote;
   wire        tx_done     = ev_ok && !ev_is_rx;
   // Remote on a transmit object
   wire        rmt_on_tx   = rx_remote && ev_dir_tx; // [RULE6]
   wire        rmt_watch   = rmt_on_tx && ev_cfg[mog_pkg::CFG_WATCH]; // [RULE1] [RULE2]
   wire        rmt_gw      = rmt_on_tx && ev_gw; // [RULE16]
   wire        rmt_fwd     = rmt_gw && ev_fg[mog_pkg::FG_FWD]; // [RULE15] [RULE17]
   // Data frame into a receive object, and normal gateway actions on it
   wire        data_store  = rx_data && !ev_dir_tx; // [RULE5]
   wire        gw_data     = data_store && ev_gw_norm; // [RULE14]
   wire        gw_send     = gw_data && ev_fg[mog_pkg::FG_SEND]; // [RULE13]
   wire        gw_idc      = gw_data && ev_fg[mog_pkg::FG_IDC]; // [RULE18]
   wire        gw_length_code_copy     = gw_data && ev_fg[mog_pkg::FG_LENGTH_CODE_COPY]; // [RULE19]
   // Host writes
   wire        wr_cfg      = host_wr && (host_sel == mog_pkg::SEL_CFG);
   wire        wr_fg       = host_wr && (host_sel == mog_pkg::SEL_FGCR);
   wire        wr_ctl      = host_wr && (host_sel == mog_pkg::SEL_CTRL);
   wire [1:0]  w_valid     = host_wdata[7:6];
   wire [1:0]  w_tx_irq_en      = host_wdata[5:4];
   wire [1:0]  w_rx_irq_en      = host_wdata[3:2];
   wire [1:0]  w_req       = host_wdata[13:12];
   wire [1:0]  w_rpnd      = host_wdata[15:14];
   wire        valid_set   = wr_ctl && (w_valid == mog_pkg::EL_SET);
   // Launch decode
   wire [31:0] tx_cfg      = cfg_mem[tx_obj];
   wire [2:0]  tx_act      = act_mem[tx_obj];
   wire [2:0]  tx_rxp      = cfg_mem[ev_obj][mog_pkg::CFG_RXP_L +: 3];
   wire [2:0]  tx_txp      = cfg_mem[ev_obj][mog_pkg::CFG_TXP_L +: 3];
   wire [31:0] rd_ctl      = {16'h0000, rpnd_reg[host_obj] ? 2'h2 : 2'h1, req_reg[host_obj] ? 2'h2 : 2'h1,
                              4'h5, valid_reg[host_obj] ? 2'h2 : 2'h1,
                              tx_irq_en_reg[host_obj] ? 2'h2 : 2'h1, rx_irq_en_reg[host_obj] ? 2'h2 : 2'h1, 2'h1};
   wire [5:0]  dd_stages;
   wire        dd_ok;

   mog_depth_decode u_depth
   (
      .depth_code (fg_mem[host_obj][4:0]),
      .stages     (dd_stages),
      .code_ok    (dd_ok)
   );

   // Configuration and identifier store
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < NUM_OBJ; i++)
         begin
            cfg_mem[i]  <= mog_pkg::CFG_RESET;
            fg_mem[i]   <= mog_pkg::FG_RESET;
            id_mem[i]   <= '0;
            act_mem[i]  <= 3'h0;
            aptr_mem[i] <= 5'h00;
         end
      end
      else
      begin
         if (wr_cfg)
            cfg_mem[host_obj] <= host_wdata & mog_pkg::CFG_RW_MASK; // [RULE12]
         if (wr_fg)
         begin
            fg_mem[host_obj] <= host_wdata & mog_pkg::FG_RW_MASK;
            if (!act_mem[host_obj][2])
               aptr_mem[host_obj] <= host_wdata[mog_pkg::FG_PTR_L +: 5];
         end
         if (wr_ctl && host_wdata[31:16] != 16'h0000)
            id_mem[host_obj] <= host_wdata[28:0] & 29'h1FFF_FFFF;
         if (valid_set)
         begin
            // Width, node and direction only move to the active copy here
            act_mem[host_obj]  <= {cfg_mem[host_obj][mog_pkg::CFG_DIR], cfg_mem[host_obj][mog_pkg::CFG_LONG],
                                   cfg_mem[host_obj][mog_pkg::CFG_NODE]}; // [RULE20] [RULE3] [RULE4]
            aptr_mem[host_obj] <= fg_mem[host_obj][mog_pkg::FG_PTR_L +: 5];
         end
         if (rmt_watch)
         begin
            id_mem[ev_obj] <= ev_id;
            cfg_mem[ev_obj][mog_pkg::CFG_DLC_L +: 4] <= ev_dlc; // [RULE1] [RULE7]
         end
         if (data_store)
            cfg_mem[ev_obj][mog_pkg::CFG_DLC_L +: 4] <= ev_dlc; // [RULE9]
         if (gw_idc)
            id_mem[ev_ptr] <= ev_id; // [RULE18]
         if (gw_length_code_copy)
            cfg_mem[ev_ptr][mog_pkg::CFG_DLC_L +: 4] <= ev_dlc; // [RULE19] [RULE7]
      end
   end

   // Control elements: hardware set wins over a software reset in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         valid_reg <= '0;
         rx_irq_en_reg  <= '0;
         tx_irq_en_reg  <= '0;
         req_reg   <= '0;
         rpnd_reg  <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_OBJ; i++)
         begin
            if (wr_ctl && host_obj == 5'(i))
            begin
               if (w_valid == mog_pkg::EL_SET) valid_reg[i] <= 1'b1;
               if (w_valid == mog_pkg::EL_RESET) valid_reg[i] <= 1'b0;
               if (w_rx_irq_en == mog_pkg::EL_SET) rx_irq_en_reg[i] <= 1'b1;
               if (w_rx_irq_en == mog_pkg::EL_RESET) rx_irq_en_reg[i] <= 1'b0;
               if (w_tx_irq_en == mog_pkg::EL_SET) tx_irq_en_reg[i] <= 1'b1;
               if (w_tx_irq_en == mog_pkg::EL_RESET) tx_irq_en_reg[i] <= 1'b0;
               if (w_req == mog_pkg::EL_SET) req_reg[i] <= 1'b1;
               if (w_req == mog_pkg::EL_RESET) req_reg[i] <= 1'b0;
               if (w_rpnd == mog_pkg::EL_SET) rpnd_reg[i] <= 1'b1;
               if (w_rpnd == mog_pkg::EL_RESET) rpnd_reg[i] <= 1'b0;
            end
            if (tx_done && ev_obj == 5'(i))
            begin
               req_reg[i]  <= 1'b0;
               rpnd_reg[i] <= 1'b0;
            end
            if (rmt_on_tx && !rmt_fwd && ev_obj == 5'(i))
            begin
               req_reg[i]  <= 1'b1; // [RULE6] [RULE15]
               rpnd_reg[i] <= 1'b1;
            end
            if (rmt_fwd && ev_ptr == 5'(i))
               req_reg[i] <= 1'b1; // [RULE15]
            if (gw_send && ev_ptr == 5'(i))
               req_reg[i] <= 1'b1; // [RULE13]
         end
      end
   end

   // Launch descriptor, receive store strobe, interrupt node pulse
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         tx_remote_reg   <= 1'b0;
         tx_node_reg     <= 1'b0;
         tx_long_reg     <= 1'b0;
         tx_id_reg       <= '0;
         tx_bytes_reg    <= 4'h0;
         store_reg       <= 1'b0;
         store_bytes_reg <= 4'h0;
         store_obj_reg   <= 5'h00;
         irq_reg         <= 8'h00;
         stages_reg      <= 6'h00;
         bad_reg         <= 1'b0;
         rdata_reg       <= 32'h0000_0000;
      end
      else
      begin
         tx_remote_reg   <= !tx_act[2]; // [RULE5]
         tx_node_reg     <= tx_act[0]; // [RULE3]
         tx_long_reg     <= tx_act[1]; // [RULE4]
         tx_id_reg       <= tx_act[1] ? id_mem[tx_obj] : {id_mem[tx_obj][28:18], 18'h00000};
         tx_bytes_reg    <= clip_dlc(tx_cfg[mog_pkg::CFG_DLC_L +: 4]); // [RULE8]
         store_reg       <= data_store; // [RULE5]
         store_bytes_reg <= clip_dlc(ev_dlc); // [RULE9]
         store_obj_reg   <= ev_obj;
         irq_reg         <= 8'h00;
         if (ev_ok && ev_is_rx && rx_irq_en_reg[ev_obj])
            irq_reg[tx_rxp] <= 1'b1; // [RULE10]
         if (tx_done && tx_irq_en_reg[ev_obj])
            irq_reg[tx_txp] <= 1'b1; // [RULE11]
         stages_reg      <= dd_stages; // [RULE22]
         bad_reg         <= !dd_ok;
         if (host_rd)
         begin
            case (host_sel)
               mog_pkg::SEL_CFG:  rdata_reg <= cfg_mem[host_obj]; // [RULE12]
               mog_pkg::SEL_FGCR: rdata_reg <= fg_mem[host_obj];
               mog_pkg::SEL_CTRL: rdata_reg <= rd_ctl;
               default:           rdata_reg <= {3'h0, id_mem[host_obj]};
            endcase
         end
      end
   end

   assign host_rdata     = rdata_reg;
   assign tx_remote      = tx_remote_reg;
   assign tx_node        = tx_node_reg;
   assign tx_long_id     = tx_long_reg;
   assign tx_id          = tx_id_reg;
   assign tx_bytes       = tx_bytes_reg;
   assign store_payload  = store_reg;
   assign store_bytes    = store_bytes_reg;
   assign store_obj      = store_obj_reg;
   assign send_request   = req_reg;
   assign remote_pending = rpnd_reg;
   assign irq_node_pulse = irq_reg;
   assign fifo_stages    = stages_reg;
   assign fifo_code_bad  = bad_reg;
endmodule : mog_gateway_cfg
`default_nettype wire

/* testbench/mog_gateway_cfg_checker.sv */
// Port assertions for the message object configuration block
`timescale 1ns/1ps
`default_nettype none
module mog_gateway_cfg_checker
#(
   parameter int NUM_OBJ = 32
)
(
   input wire logic               clk,
   input wire logic               rstn,
   input wire logic               host_rd,
   input wire logic [1:0]         host_sel,
   input wire logic [31:0]        host_rdata,
   input wire logic               ev_valid,
   input wire logic               ev_remote,
   input wire logic               ev_is_rx,
   input wire logic [3:0]         tx_bytes,
   input wire logic               store_payload,
   input wire logic [3:0]         store_bytes,
   input wire logic [NUM_OBJ-1:0] send_request,
   input wire logic [NUM_OBJ-1:0] remote_pending,
   input wire logic [7:0]         irq_node_pulse,
   input wire logic [5:0]         fifo_stages,
   input wire logic               fifo_code_bad
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [NUM_OBJ-1:0] pend_prev;
   wire  [NUM_OBJ-1:0] pend_new = remote_pending & ~pend_prev;
   always_ff @(posedge clk)
      pend_prev <= remote_pending;
   sequence rx_data_ev;
      ev_valid && ev_is_rx && !ev_remote;
   endsequence
   sequence rx_remote_ev;
      ev_valid && ev_is_rx && ev_remote;
   endsequence
   AST_CFG_RSVD: assert property (host_rd && host_sel == 2'h0 |=> (host_rdata & 32'hFF88_FF00) == 32'h0)
      else $error("reserved config bits not zero");
   AST_STORE_CLIP: assert property (store_payload |-> store_bytes <= 4'h8)
      else $error("stored byte count above eight");
   AST_TX_CLIP: assert property (tx_bytes <= 4'h8)
      else $error("transmit byte count above eight");
   AST_STORE_CAUSE: assert property (store_payload |-> $past(ev_valid && ev_is_rx && !ev_remote))
      else $error("payload stored without received data frame");
   AST_RMT_NO_STORE: assert property (rx_remote_ev |=> !store_payload)
      else $error("remote frame stored a payload");
   AST_PEND_CAUSE: assert property (pend_new != '0 |-> $past(ev_valid && ev_remote))
      else $error("remote pending set without remote frame");
   AST_PEND_REQ: assert property (pend_new != '0 |-> (send_request & pend_new) == pend_new)
      else $error("remote pending set without send request");
   AST_IRQ_ONE: assert property ($onehot0(irq_node_pulse))
      else $error("more than one interrupt node pulsed");
   AST_IRQ_CAUSE: assert property (irq_node_pulse != 8'h00 |-> $past(ev_valid))
      else $error("interrupt pulse without frame event");
   AST_DEPTH: assert property (!fifo_code_bad |-> $onehot0(fifo_stages))
      else $error("fifo stage count not a power of two");
   cover property (rx_data_ev ##1 store_payload);
endmodule : mog_gateway_cfg_checker
bind mog_gateway_cfg mog_gateway_cfg_checker #(.NUM_OBJ(NUM_OBJ)) u_chk
(
   .clk(clk), .rstn(rstn), .host_rd(host_rd), .host_sel(host_sel), .host_rdata(host_rdata),
   .ev_valid(ev_valid), .ev_remote(ev_remote), .ev_is_rx(ev_is_rx), .tx_bytes(tx_bytes),
   .store_payload(store_payload), .store_bytes(store_bytes), .send_request(send_request),
   .remote_pending(remote_pending), .irq_node_pulse(irq_node_pulse), .fifo_stages(fifo_stages),
   .fifo_code_bad(fifo_code_bad)
);
`default_nettype wire

/* testbench/mog_can_peer.sv */
// Remote nodes on both buses, reported as frame events
`timescale 1ns/1ps
`default_nettype none
module mog_can_peer
(
   input  wire logic        clk,
   output logic             ev_valid,
   output logic             ev_node,
   output logic [4:0]       ev_obj,
   output logic             ev_remote,
   output logic             ev_is_rx,
   output logic [28:0]      ev_id,
   output logic [3:0]       ev_dlc
);
   initial ev_valid = 1'b0;
   initial {ev_node, ev_obj, ev_remote, ev_is_rx, ev_id, ev_dlc} = '0;
   task automatic send(input logic nd, input logic [4:0] ob, input logic rm, input logic rx,
                       input logic [28:0] id, input logic [3:0] dl);
      @(negedge clk);
      {ev_valid, ev_node, ev_obj, ev_remote, ev_is_rx, ev_id, ev_dlc} = {1'b1, nd, ob, rm, rx, id, dl};
      @(negedge clk);
      ev_valid = 1'b0;
      // Stale identifier and length fields are scrambled so nothing can lean on them
      ev_id = ~ev_id;
      ev_dlc = ~ev_dlc;
   endtask : send
endmodule : mog_can_peer
`default_nettype wire

/* testbench/mog_gateway_cfg_tb.sv */
// Self-checking bench for the message object configuration block
`timescale 1ns/1ps
`default_nettype none
module mog_gateway_cfg_tb;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        host_wr = 1'b0;
   logic        host_rd = 1'b0;
   logic [1:0]  host_sel = 2'h0;
   logic [4:0]  host_obj = 5'h00;
   logic [31:0] host_wdata = 32'h0;
   logic [4:0]  tx_obj = 5'h00;
   logic [31:0] host_rdata, send_request, remote_pending, d;
   logic        ev_valid, ev_node, ev_remote, ev_is_rx, tx_remote, tx_node, tx_long_id, store_payload;
   logic        fifo_code_bad, st_seen;
   logic [4:0]  ev_obj, store_obj, st_obj;
   logic [28:0] ev_id, tx_id;
   logic [3:0]  ev_dlc, tx_bytes, store_bytes, st_bytes;
   logic [7:0]  irq_node_pulse, irq_seen;
   logic [5:0]  fifo_stages;
   int          num_errors = 0;
   int          cmp_count = 0;
   mog_gateway_cfg uut
   (
      .clk(clk), .rstn(rstn), .host_wr(host_wr), .host_rd(host_rd), .host_sel(host_sel),
      .host_obj(host_obj), .host_wdata(host_wdata), .host_rdata(host_rdata), .ev_valid(ev_valid),
      .ev_node(ev_node), .ev_obj(ev_obj), .ev_remote(ev_remote), .ev_is_rx(ev_is_rx), .ev_id(ev_id),
      .ev_dlc(ev_dlc), .tx_obj(tx_obj), .tx_remote(tx_remote), .tx_node(tx_node), .tx_long_id(tx_long_id),
      .tx_id(tx_id), .tx_bytes(tx_bytes), .store_payload(store_payload), .store_bytes(store_bytes),
      .store_obj(store_obj), .send_request(send_request), .remote_pending(remote_pending),
      .irq_node_pulse(irq_node_pulse), .fifo_stages(fifo_stages), .fifo_code_bad(fifo_code_bad)
   );
   mog_can_peer peer
   (
      .clk(clk), .ev_valid(ev_valid), .ev_node(ev_node), .ev_obj(ev_obj), .ev_remote(ev_remote),
      .ev_is_rx(ev_is_rx), .ev_id(ev_id), .ev_dlc(ev_dlc)
   );
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // Pulses are caught here so checks do not hinge on the exact sampling cycle
   always @(posedge clk)
   begin
      if (store_payload === 1'b1)
      begin
         st_seen <= 1'b1;
         st_bytes <= store_bytes;
         st_obj <= store_obj;
      end
      irq_seen <= irq_seen | irq_node_pulse;
   end
   task automatic report_and_stop;
      if (num_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [1:0] s, input logic [4:0] o, input logic [31:0] wd);
      @(negedge clk);
      {host_sel, host_obj, host_wdata, host_wr, host_rd} = {s, o, wd, w, ~w};
      @(negedge clk);
      {host_wr, host_rd} = 2'b00;
      @(negedge clk);
      d = host_rdata;
   endtask : acc
   task automatic frame(input logic nd, input logic [4:0] ob, input logic rm, input logic rx,
                        input logic [28:0] id, input logic [3:0] dl);
      st_seen = 1'b0;
      irq_seen = 8'h00;
      peer.send(nd, ob, rm, rx, id, dl);
      repeat (3) @(negedge clk);
   endtask : frame
   task automatic t_regs;
      acc(1'b0, 2'h0, 5'd0, 32'h0);
      cmp(d, mog_pkg::CFG_RESET);
      acc(1'b0, 2'h1, 5'd0, 32'h0);
      cmp(d, mog_pkg::FG_RESET);
      acc(1'b1, 2'h0, 5'd1, 32'hFFFF_FFFF);
      acc(1'b0, 2'h0, 5'd1, 32'h0);
      cmp(d & 32'hFF88_FF00, 32'h0);
      acc(1'b1, 2'h1, 5'd2, 32'h0000_0007);
      cmp({fifo_code_bad, fifo_stages}, {1'b0, 6'h08});
      acc(1'b1, 2'h1, 5'd2, 32'h0000_0005);
      cmp(fifo_code_bad, 1'b1);
   endtask : t_regs
   task automatic t_tx_obj;
      acc(1'b1, 2'h0, 5'd3, 32'h0000_00FE);
      tx_obj = 5'd3;
      repeat (2) @(negedge clk);
      cmp(tx_node, 1'b0);
      acc(1'b1, 2'h2, 5'd3, 32'h0000_FF80);
      cmp({tx_node, tx_long_id, tx_remote}, 3'b110);
      cmp(tx_bytes, 4'h8);
      acc(1'b0, 2'h0, 5'd3, 32'h0);
      cmp(d, 32'h0000_00FE);
      acc(1'b1, 2'h0, 5'd3, 32'h0000_00FF);
      frame(1'b1, 5'd3, 1'b1, 1'b1, 29'h1ABC_DE5, 4'h3);
      cmp({send_request[3], remote_pending[3]}, 2'b11);
      acc(1'b0, 2'h3, 5'd3, 32'h0);
      cmp(d, 32'h1ABC_DE5);
      cmp(tx_id, 29'h1ABC_DE5);
      acc(1'b0, 2'h0, 5'd3, 32'h0);
      cmp(d & 32'hF0, 32'h30);
      acc(1'b1, 2'h0, 5'd3, 32'h0060_00FF);
      acc(1'b1, 2'h2, 5'd3, 32'h0000_FFEF);
      frame(1'b1, 5'd3, 1'b0, 1'b0, 29'h0, 4'h0);
      cmp(irq_seen, 8'h40);
   endtask : t_tx_obj
   task automatic t_rx_obj;
      acc(1'b1, 2'h0, 5'd4, 32'h0005_0001);
      acc(1'b1, 2'h2, 5'd4, 32'h0000_FFBB);
      tx_obj = 5'd4;
      repeat (2) @(negedge clk);
      cmp({tx_remote, tx_node}, 2'b10);
      frame(1'b0, 5'd4, 1'b0, 1'b1, 29'h0000_123, 4'hC);
      cmp({st_seen, st_obj, st_bytes}, {1'b1, 5'd4, 4'h8});
      cmp(irq_seen, 8'h20);
      acc(1'b0, 2'h0, 5'd4, 32'h0);
      cmp(d & 32'hF0, 32'hC0);
      frame(1'b0, 5'd4, 1'b1, 1'b1, 29'h0000_456, 4'h1);
      cmp({send_request[4], remote_pending[4]}, 2'b00);
      frame(1'b1, 5'd4, 1'b0, 1'b1, 29'h0000_123, 4'h2);
      cmp(st_seen, 1'b0);
   endtask : t_rx_obj
   task automatic t_gateway;
      acc(1'b1, 2'h2, 5'd6, 32'h0000_FFBF);
      acc(1'b1, 2'h1, 5'd6, 32'h0407_0D00);
      acc(1'b1, 2'h0, 5'd7, 32'h0000_000A);
      acc(1'b1, 2'h2, 5'd7, 32'h0000_FFBF);
      frame(1'b0, 5'd6, 1'b0, 1'b1, 29'h0ABC_123, 4'h5);
      cmp(send_request[7], 1'b1);
      acc(1'b0, 2'h3, 5'd7, 32'h0);
      cmp(d, 32'h0ABC_123);
      acc(1'b0, 2'h0, 5'd7, 32'h0);
      cmp(d & 32'hF0, 32'h50);
      acc(1'b1, 2'h2, 5'd7, 32'h0000_DFFF);
      acc(1'b1, 2'h1, 5'd6, 32'h0407_0000);
      frame(1'b0, 5'd6, 1'b0, 1'b1, 29'h0000_777, 4'h2);
      cmp(send_request[7], 1'b0);
      acc(1'b0, 2'h3, 5'd7, 32'h0);
      cmp(d, 32'h0ABC_123);
      acc(1'b1, 2'h1, 5'd7, 32'h0406_0200);
      acc(1'b1, 2'h2, 5'd7, 32'h0000_FFBF);
      frame(1'b1, 5'd7, 1'b1, 1'b1, 29'h0000_777, 4'h0);
      cmp({send_request[6], send_request[7]}, 2'b10);
   endtask : t_gateway
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      t_regs();
      t_tx_obj();
      t_rx_obj();
      t_gateway();
      report_and_stop();
   end
endmodule : mog_gateway_cfg_tb
`default_nettype wire
